// >>> hw/frs_seq.sv
// Reset sequencer of a serial flash: cold, warm and software reset
`timescale 1ns/1ns

// Behaviour
// RULE1 - Power-on reset runs for the power-up time; host stays deselected meanwhile.
// RULE2 - Shared pin is reset only after select high time or with quad off.
// RULE3 - Reset low is ignored while power-on reset runs.
// RULE4 - Reset low past power-up: host holds select high until hold time after release.
// RULE5 - Host holds reset high for setup time before a new reset low.
// RULE6 - Shared pin has an internal pull-up; undriven reads high.
// RULE7 - Pin ignored during select high time after rise; data line when selected.
// RULE8 - Low for pulse width resets registers; completion takes recovery time.
// RULE9 - Failed power-on reset: later reset low reruns full power-on process.
// RULE10 - Reset command performs software reset regardless of shared pin level.
// RULE11 - Hardware reset aborts work, floats outputs, ignores commands for recovery time.
// RULE12 - After quad read, device drives shared pin high during select high time.
// RULE13 - After quad write, host drives shared pin high during select high time.
// RULE14 - Quad off, select low at reset: host raises select within recovery time.
// RULE15 - Host ensures reset low plus hold time covers recovery time.
// RULE16 - Reset held at end of power-up keeps device in reset until release.
// RULE17 - Reset pin enable gates pin reset; with quad, select high time lengthens.
// RULE18 - Pulses shorter than pulse width start no warm reset.
module frs_seq
    import frs_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_CYC,
    parameter int RECOVERY_CYCLES = RESET_RECOVERY_CYC
) (
    input wire logic I_MCLK,            // 250 MHz clock
    input wire logic I_RSTN,            // Async reset, low active
    input wire logic I_CS_N,            // Chip select, low active
    input wire logic I_IO3_IN,          // Shared pin level as seen
    input wire logic I_IO3_DRIVEN,      // Some party drives the pin
    input wire logic I_QUAD_ENABLE,     // Quad mode enable bit
    input wire logic I_RESET_PIN_EN,    // Reset pin function enable bit
    input wire logic I_QUAD_READ_DONE,  // Pulse: quad output command ended
    input wire logic I_SW_RESET_CMD,    // Pulse: reset command decoded
    input wire logic I_POR_FAIL,        // Pulse: power-on check failed
    output logic O_BUSY,                // Reset in progress, commands ignored
    output logic O_IN_RESET,            // Outputs forced to high impedance
    output logic O_HW_RESET,            // Pulse: register reset request
    output logic O_SW_RESET,            // Pulse: software reset request
    output logic O_IO3_OUT,             // Shared pin drive value
    output logic O_IO3_OE,              // Shared pin drive enable
    output logic O_POR_DONE             // Power-on reset completed
);

    // ****************************************
    // State
    // ****************************************
    frs_regs_t r;
    frs_regs_t n;
    logic pin_level;
    logic pin_is_reset;
    logic [7:0] cs_need;

    // RULE6 pull-up model
    assign pin_level = I_IO3_DRIVEN ? I_IO3_IN : 1'b1;

    // RULE17 longer select time for quad with reset pin
    assign cs_need = (I_QUAD_ENABLE && I_RESET_PIN_EN) ? 8'(SELECT_HIGH_QR_CYC)
                                                       : 8'(SELECT_HIGH_CYC);

    // RULE2 pin role selection
    // RULE7 data line while selected, masked in select high window
    assign pin_is_reset = I_RESET_PIN_EN &&
        (!I_QUAD_ENABLE || (I_CS_N && r.cs_high_cnt >= cs_need));

    always_comb begin
        n = r;
        n.hw_reset_pulse = 1'b0;
        n.sw_reset_pulse = 1'b0;
        if (!I_CS_N) begin
            n.cs_high_cnt = '0;
        end else if (r.cs_high_cnt != 8'hFF) begin
            n.cs_high_cnt = r.cs_high_cnt + 8'h01;
        end
        // RULE12 hold pin high after quad read
        if (I_QUAD_READ_DONE && I_QUAD_ENABLE) begin
            n.io3_drive = 1'b1;
        end else if (!I_CS_N || r.cs_high_cnt >= cs_need) begin
            n.io3_drive = 1'b0;
        end
        if (I_POR_FAIL) begin
            n.por_ok = 1'b0;
        end
        case (r.state)
            FRS_POR: begin
                // RULE1 RULE3 count power-up, pin ignored
                n.busy = 1'b1;
                n.in_reset = 1'b1;
                if (r.cnt >= CNT_W'(POWER_UP_CYCLES - 1)) begin
                    n.cnt = '0;
                    n.por_ok = !I_POR_FAIL && r.por_ok;
                    n.state = (pin_is_reset && !pin_level) ? FRS_POR_HELD : FRS_SETUP;
                end else begin
                    n.cnt = r.cnt + CNT_W'(1);
                end
            end
            FRS_POR_HELD: begin
                // RULE16 stay in reset until release
                if (pin_level) begin
                    n.state = FRS_SETUP;
                    n.cnt = '0;
                end
            end
            FRS_SETUP: begin
                // RULE5 setup window before a new reset
                n.busy = 1'b0;
                n.in_reset = 1'b0;
                if (!pin_level) begin
                    n.cnt = '0;
                end else if (r.cnt >= CNT_W'(RESET_SETUP_CYC - 1)) begin
                    n.state = FRS_READY;
                    n.cnt = '0;
                end else begin
                    n.cnt = r.cnt + CNT_W'(1);
                end
            end
            FRS_READY: begin
                if (I_SW_RESET_CMD) begin
                    // RULE10 command independent of pin
                    n.sw_reset_pulse = 1'b1;
                end
                if (pin_is_reset && !pin_level) begin
                    n.state = FRS_PULSE;
                    n.cnt = CNT_W'(1);
                end
            end
            FRS_PULSE: begin
                // RULE18 short pulse has no effect
                // RULE2 pin must still act as reset
                if (pin_is_reset && !pin_level) begin
                    n.cnt = r.cnt + CNT_W'(1);
                    if (r.cnt >= CNT_W'(RESET_PULSE_CYC - 1)) begin
                        n.cnt = '0;
                        if (!r.por_ok) begin
                            // RULE9 rerun full power-on
                            n.state = FRS_POR;
                            n.por_ok = !I_POR_FAIL;
                            n.busy = 1'b1;
                            n.in_reset = 1'b1;
                        end else begin
                            // RULE8 RULE11 warm reset
                            n.state = FRS_WARM;
                            n.hw_reset_pulse = 1'b1;
                            n.busy = 1'b1;
                            n.in_reset = 1'b1;
                        end
                    end
                end else begin
                    n.state = FRS_READY;
                    n.cnt = '0;
                end
            end
            FRS_WARM: begin
                // RULE11 ignore commands for recovery time
                if (r.cnt >= CNT_W'(RECOVERY_CYCLES - 1)) begin
                    n.state = FRS_SETUP;
                    n.cnt = '0;
                end else begin
                    n.cnt = r.cnt + CNT_W'(1);
                end
            end
            default: begin
                n.state = FRS_POR;
            end
        endcase
        // Registered so the flag leaves straight from a flip-flop
        n.por_done = (n.state != FRS_POR);
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r <= '{state: FRS_POR, cnt: '0, cs_high_cnt: '0, por_ok: 1'b1,
                   in_reset: 1'b1, hw_reset_pulse: 1'b0, sw_reset_pulse: 1'b0,
                   io3_drive: 1'b0, busy: 1'b1, por_done: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign O_BUSY = r.busy;
    assign O_IN_RESET = r.in_reset;
    assign O_HW_RESET = r.hw_reset_pulse;
    assign O_SW_RESET = r.sw_reset_pulse;
    assign O_IO3_OUT = r.io3_drive;
    assign O_IO3_OE = r.io3_drive;
    assign O_POR_DONE = r.por_done;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);

    sequence s_warm_start;
        r.state == FRS_PULSE ##1 r.state == FRS_WARM;
    endsequence

    sequence s_rerun_start;
        r.state == FRS_PULSE ##1 r.state == FRS_POR;
    endsequence

    chk_warm_busy: assert property (s_warm_start |-> O_BUSY && O_IN_RESET) // RULE11
        else $error("Warm reset not flagged busy");
    chk_warm_pulse: assert property (s_warm_start |-> O_HW_RESET) // RULE8
        else $error("Warm reset missing register reset pulse");
    chk_por_ignore: assert property (r.state == FRS_POR && !$rose(O_POR_DONE) |=> // RULE3
        !O_HW_RESET) else $error("Reset acted during power-on");
    chk_pulse_short: assert property ($rose(r.state == FRS_PULSE) ##1 pin_level // RULE18
        |=> !O_HW_RESET) else $error("Short pulse started reset");
    chk_cs_mask: assert property (!I_CS_N && I_QUAD_ENABLE |-> !pin_is_reset) // RULE7
        else $error("Pin used as reset while selected");
    chk_sw_reset: assert property (r.state == FRS_READY && I_SW_RESET_CMD |=> // RULE10
        O_SW_RESET) else $error("Software reset lost");
    chk_io3_high: assert property (O_IO3_OE |-> O_IO3_OUT) // RULE12
        else $error("Shared pin driven low");
    chk_por_busy: assert property (r.state == FRS_POR |-> O_BUSY) // RULE1
        else $error("Not busy during power-on");
    chk_pin_role: assert property (!I_RESET_PIN_EN |-> !pin_is_reset) // RULE17
        else $error("Reset pin disabled yet used");
    chk_read_drive: assert property (I_QUAD_READ_DONE && I_QUAD_ENABLE |=> // RULE12
        O_IO3_OE && O_IO3_OUT) else $error("Shared pin not driven high after read");
    chk_held_busy: assert property (r.state == FRS_POR_HELD |-> O_BUSY && O_IN_RESET) // RULE16
        else $error("Held reset not flagged busy");
    chk_rerun_busy: assert property (s_rerun_start |-> O_BUSY && !O_POR_DONE) // RULE9
        else $error("Power-on rerun not flagged busy");

endmodule : frs_seq

// >>> hw/frs_pkg.sv
// Package for the flash reset sequencer: timing constants, states, carriers
package frs_pkg;

    // ****************************************
    // Timing, in nanoseconds and clock cycles
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int POWER_UP_TIME_NS = 300000;
    localparam int SELECT_HIGH_TIME_NS = 10;
    localparam int SELECT_HIGH_TIME_QR_NS = 20;
    localparam int RESET_PULSE_WIDTH_NS = 200;
    localparam int RESET_RECOVERY_TIME_NS = 35000;
    localparam int RESET_SETUP_TIME_NS = 50;
    localparam int RESET_HOLD_TIME_NS = 50;

    // Least times round up
    localparam int SELECT_HIGH_CYC = (SELECT_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_HIGH_QR_CYC =
        (SELECT_HIGH_TIME_QR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVERY_CYC =
        (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_SETUP_CYC = (RESET_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC = (POWER_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 20;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [2:0] {
        FRS_POR,
        FRS_POR_HELD,
        FRS_READY,
        FRS_PULSE,
        FRS_WARM,
        FRS_SETUP
    } frs_state_t;

    typedef struct packed {
        logic quad_enable_bit;
        logic reset_pin_enable_bit;
    } frs_cfg_t;

    typedef struct packed {
        frs_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [7:0] cs_high_cnt;
        logic por_ok;
        logic in_reset;
        logic hw_reset_pulse;
        logic sw_reset_pulse;
        logic io3_drive;
        logic busy;
        logic por_done;
    } frs_regs_t;

endpackage : frs_pkg

// >>> tb/frs_host_model.sv
// Host controller model driving select and the shared pin
`timescale 1ns/1ns
module frs_host_model (
    input wire logic i_clk,       // Clock
    input wire logic i_sel,       // Hold select low
    input wire logic [7:0] i_low, // Reset low length in cycles
    input wire logic i_go,        // Start a reset pulse
    output logic o_cs_n,          // Chip select
    output logic o_io3_out,       // Pin drive value
    output logic o_io3_oe,        // Pin drive enable
    output logic o_done           // Pulse finished
);
    initial begin
        o_cs_n = 1'b1;
        o_io3_out = 1'b1;
        o_io3_oe = 1'b0;
        o_done = 1'b0;
        forever begin
            @(posedge i_clk);
            o_cs_n <= !i_sel;
            if (i_go) begin
                repeat (20) @(posedge i_clk);
                o_io3_oe <= 1'b1;
                o_io3_out <= 1'b0;
                repeat (i_low) @(posedge i_clk);
                o_io3_out <= 1'b1;
                @(posedge i_clk);
                o_io3_oe <= 1'b0;
                o_done <= 1'b1;
                @(posedge i_clk);
                o_done <= 1'b0;
            end
        end
    end
endmodule : frs_host_model

// >>> tb/frs_seq_tb_top.sv
// Testbench of the flash reset sequencer against a host model
`timescale 1ns/1ns
module frs_seq_tb_top;
    import frs_pkg::*;
    // Go starts high so the host pulls the pin low across the end of power-up
    logic clk = 0, rstn = 0, sel = 0, go = 1, qen = 0, pen = 1, qrd = 0, swc = 0, pf = 0;
    logic [7:0] low = 8'h1e;
    logic cs_n, h_out, h_oe, h_done, busy, inr, hw, sw, d_out, d_oe, pdone, lvl;
    int mismatches = 0, samples_checked = 0, hw_n = 0, sw_n = 0, busy_n = 0;
    always #2 clk = ~clk;
    // Undriven pin floats up through the pull-up
    assign lvl = d_oe ? d_out : (h_oe ? h_out : 1'b1);
    frs_host_model host (.i_clk(clk), .i_sel(sel), .i_low(low), .i_go(go), .o_cs_n(cs_n),
        .o_io3_out(h_out), .o_io3_oe(h_oe), .o_done(h_done));
    frs_seq #(.POWER_UP_CYCLES(20), .RECOVERY_CYCLES(30)) dut (.I_MCLK(clk), .I_RSTN(rstn),
        .I_CS_N(cs_n), .I_IO3_IN(lvl), .I_IO3_DRIVEN(d_oe | h_oe), .I_QUAD_ENABLE(qen),
        .I_RESET_PIN_EN(pen), .I_QUAD_READ_DONE(qrd), .I_SW_RESET_CMD(swc),
        .I_POR_FAIL(pf), .O_BUSY(busy), .O_IN_RESET(inr), .O_HW_RESET(hw), .O_SW_RESET(sw),
        .O_IO3_OUT(d_out), .O_IO3_OE(d_oe), .O_POR_DONE(pdone));
    always @(posedge clk) begin
        if (hw === 1'b1) hw_n <= hw_n + 1;
        if (sw === 1'b1) sw_n <= sw_n + 1;
        if (busy === 1'b1) busy_n <= busy_n + 1;
    end
    task check(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task pulse(input logic [7:0] n);
        int i;
        low <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 300 && h_done !== 1'b1; i++) @(posedge clk);
        check("host pulse done", 1'b1, h_done);
    endtask : pulse
    task idle;
        int i;
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        check("recovery ended", 1'b0, busy);
        repeat (20) @(posedge clk);
    endtask : idle
    task t_por;
        int i;
        @(posedge clk);
        go <= 1'b0;
        // First edge only loads the reset values
        @(posedge clk);
        check("busy in reset", 1'b1, busy);
        check("por done in reset", 1'b0, pdone);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        // Pin is still low here, after power-up has ended
        repeat (25) @(posedge clk);
        check("held past power-up", 1'b1, busy);
        check("power-up over", 1'b1, pdone);
        for (i = 0; i < 300 && h_done !== 1'b1; i++) @(posedge clk);
        check("host pulse done", 1'b1, h_done);
        check("reset during por", 1'b1, hw_n == 0);
        idle;
        check("por done", 1'b1, pdone);
    endtask : t_por
    task t_warm;
        int h, b;
        h = hw_n;
        b = busy_n;
        pulse(8'h3c);
        check("warm reset pulse", 1'b1, hw_n == h + 1);
        check("busy in recovery", 1'b1, busy);
        check("outputs floated", 1'b1, inr);
        idle;
        check("recovery length", 1'b1, busy_n - b >= 30);
        pulse(8'h28);
        check("short pulse", 1'b1, hw_n == h + 1);
    endtask : t_warm
    task t_gate;
        int h;
        h = hw_n;
        pen <= 1'b0;
        pulse(8'h3c);
        check("pin disabled", 1'b1, hw_n == h);
        pen <= 1'b1;
        qen <= 1'b1;
        sel <= 1'b1;
        pulse(8'h3c);
        check("selected quad", 1'b1, hw_n == h);
        sel <= 1'b0;
        qen <= 1'b0;
        idle;
    endtask : t_gate
    task t_quad;
        int h;
        h = hw_n;
        qen <= 1'b1;
        pulse(8'h3c);
        check("quad deselected reset", 1'b1, hw_n == h + 1);
        idle;
        qen <= 1'b0;
        sel <= 1'b1;
        pulse(8'h3c);
        sel <= 1'b0;
        check("quad off selected reset", 1'b1, hw_n == h + 2);
        check("busy while selected", 1'b1, busy);
        idle;
    endtask : t_quad
    task t_sw;
        int h;
        h = sw_n;
        swc <= 1'b1;
        @(posedge clk);
        swc <= 1'b0;
        repeat (3) @(posedge clk);
        check("software reset", 1'b1, sw_n == h + 1);
    endtask : t_sw
    task t_qread;
        qen <= 1'b1;
        sel <= 1'b1;
        repeat (5) @(posedge clk);
        sel <= 1'b0;
        qrd <= 1'b1;
        @(posedge clk);
        qrd <= 1'b0;
        @(posedge clk);
        check("pin drive enable", 1'b1, d_oe);
        check("pin drive value", 1'b1, d_out);
        qen <= 1'b0;
        repeat (10) @(posedge clk);
        check("pin drive released", 1'b0, d_oe);
    endtask : t_qread
    task t_porfail;
        pf <= 1'b1;
        @(posedge clk);
        pf <= 1'b0;
        pulse(8'h3c);
        check("full por rerun", 1'b0, pdone);
        idle;
        check("por done again", 1'b1, pdone);
    endtask : t_porfail
    initial begin
        t_por;
        t_warm;
        t_gate;
        t_quad;
        t_sw;
        t_qread;
        t_porfail;
        finish_test;
    end
    initial begin
        #40000;
        mismatches++;
        finish_test;
    end
endmodule : frs_seq_tb_top
